//--- src/scr_control_bank.sv
// stepper driver control register bank behind the spi slave port
//
// Overview of operation
// - four read/write control registers, all bits zero after reset
// - register 0x00: watchdog enable bit 7, timeout select 6:3, rest zero
// - writing watchdog enable zero clears the watchdog event flag, unless a timeout fires in the same cycle
// - writing watchdog enable one starts or restarts the watchdog count
// - watchdog enable zero stops the watchdog; no timeout then
// - counter-clockwise when direction pin differs from invert bit 0x02.7
// - slope field 0x02 bits 1:0: very fast, fast, slow, very slow
// - motor enable 0x03 bit 7 gates the coil drivers
// - step polarity 0x02 bit 6: rising edge when zero, falling when one
// - 0x02 bit 3 doubles pwm frequency, bit 2 enables pwm jitter
// - step mode 0x01 bits 7:5 selects step size; code 111 unavailable
// - 0x03 bit 5 selects load-angle gain 0.5 or 0.25
// - 0x03 bit 4 makes load-angle output transparent
// - sleep bit 0x03.6 ignores step and direction, keeps registers and spi
// - watchdog timeout is (select plus one) times 32 ms
// - current field 0x01 bits 4:0 selects peak coil current
`timescale 1ns/1ps
`include "scr_regs.svh"
module scr_control_bank
  import scr_pkg::*;
#(
  parameter int unsigned WDOG_UNIT_CYCLES = `SCR_WDOG_UNIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic step_input,
  input wire logic dir_input,
  output logic step_advance,
  output logic dir_ccw,
  output logic [2:0] step_mode_select,
  output logic step_mode_valid,
  output logic [4:0] current_amplitude_select,
  output logic [1:0] slope_select,
  output logic pwm_double_freq,
  output logic pwm_jitter_en,
  output logic motor_enable,
  output logic sleep_mode,
  output logic sla_gain_quarter,
  output logic sla_transparent,
  output logic watchdog_enable,
  output logic watchdog_event_flag,
  output logic watchdog_timeout
);

  function automatic logic [7:0] scr_wmask(input logic [1:0] idx);
    unique case (idx)
      `SCR_IDX_WDOG: scr_wmask = `SCR_MASK_WDOG;
      `SCR_IDX_STEP: scr_wmask = `SCR_MASK_STEP;
      `SCR_IDX_DIR: scr_wmask = `SCR_MASK_DIR;
      `SCR_IDX_MOT: scr_wmask = `SCR_MASK_MOT;
    endcase
  endfunction

  scr_bank_s q, d;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_stb;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_hit, wd_write, wd_kick, wd_clear;
  logic [1:0] wr_idx;
  logic [7:0] wd_reg, dir_reg, mot_reg;
  logic asleep, step_edge;

  scr_spi_port scr_spi_port_inst (
    .core_clk(core_clk),
    .srst(srst),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // addresses past the control block (status space) read as zero here
  assign rd_data = (rd_addr < `SCR_NUM_REGS) ? q.ctrl[rd_addr[1:0]]
                                             : `SCR_READ_ZERO;

  assign wr_idx = wr_addr[1:0];
  assign wr_hit = wr_stb & (wr_addr < `SCR_NUM_REGS);
  assign wd_write = wr_hit & (wr_addr == `SCR_ADDR_WDOG);
  assign wd_kick = wd_write & wr_data[`SCR_BIT_WD_EN];
  assign wd_clear = wd_write & ~wr_data[`SCR_BIT_WD_EN];

  assign wd_reg = q.ctrl[`SCR_IDX_WDOG];
  assign dir_reg = q.ctrl[`SCR_IDX_DIR];
  assign mot_reg = q.ctrl[`SCR_IDX_MOT];
  assign asleep = mot_reg[`SCR_BIT_SLEEP];

  scr_watchdog #(
    .UNIT_CYCLES(WDOG_UNIT_CYCLES)
  ) scr_watchdog_inst (
    .core_clk(core_clk),
    .srst(srst),
    .enable(wd_reg[`SCR_BIT_WD_EN]),
    .kick(wd_kick),
    .clear_flag(wd_clear),
    .timeout_sel(wd_reg[`SCR_WDT_HI:`SCR_WDT_LO]),
    .event_flag(watchdog_event_flag),
    .timeout(watchdog_timeout)
  );

  always_comb begin
    d = q;
    d.step_q = step_input;
    // polarity bit picks which step edge counts
    step_edge = scr_edge(step_input, q.step_q, dir_reg[`SCR_BIT_STEP_POL]);
    // sleep drops step edges and freezes direction
    d.step_adv = step_edge & ~asleep;
    if (!asleep) begin
      d.dir_ccw = dir_input ^ dir_reg[`SCR_BIT_DIR_INV];
    end
    // masking keeps fixed-zero bits from ever storing
    if (wr_hit) begin
      d.ctrl[wr_idx] = wr_data & scr_wmask(wr_idx);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q.ctrl <= {4{`SCR_RESET_VAL}};
      q.step_q <= 1'b0;
      q.step_adv <= 1'b0;
      q.dir_ccw <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign step_advance = q.step_adv;
  assign dir_ccw = q.dir_ccw;
  assign step_mode_select =
    q.ctrl[`SCR_IDX_STEP][`SCR_SM_HI:`SCR_SM_LO];
  assign step_mode_valid = step_mode_select != `SCR_SM_NOT_AVAIL;
  assign current_amplitude_select =
    q.ctrl[`SCR_IDX_STEP][`SCR_CUR_HI:`SCR_CUR_LO];
  assign slope_select = dir_reg[`SCR_SLOPE_HI:`SCR_SLOPE_LO];
  assign pwm_double_freq = dir_reg[`SCR_BIT_PWM_DBL];
  assign pwm_jitter_en = dir_reg[`SCR_BIT_PWM_JIT];
  assign motor_enable = mot_reg[`SCR_BIT_MOT_EN];
  assign sleep_mode = asleep;
  assign sla_gain_quarter = mot_reg[`SCR_BIT_SLA_GAIN];
  assign sla_transparent = mot_reg[`SCR_BIT_SLA_TRANSP];
  assign watchdog_enable = wd_reg[`SCR_BIT_WD_EN];

endmodule

//--- src/scr_pkg.sv
// shared types and helper functions for the stepper control bank
package scr_pkg;

  typedef enum logic [1:0] {
    SCR_PH_IDLE = 2'b00,
    SCR_PH_CMD = 2'b01,
    SCR_PH_DATA = 2'b11
  } scr_phase_e;

  typedef struct packed {
    scr_phase_e phase;
    logic sclk_q;
    logic csn_q;
    logic [2:0] bitpos;
    logic [4:0] len;
    logic [7:0] shin;
    logic [7:0] shout;
    logic [4:0] addr;
    logic wr_cmd;
    logic [7:0] wdata;
    logic wr_stb;
  } scr_spi_s;

  typedef struct packed {
    logic [19:0] div;
    logic [3:0] units;
    logic flag;
    logic timeout;
  } scr_wdog_s;

  typedef struct packed {
    logic [3:0][7:0] ctrl;
    logic step_q;
    logic step_adv;
    logic dir_ccw;
  } scr_bank_s;

  function automatic logic scr_edge(input logic cur, input logic prev,
                                    input logic falling);
    scr_edge = falling ? (~cur & prev) : (cur & ~prev);
  endfunction

endpackage

//--- src/scr_regs.svh
// register map, field positions, reset values and timing for the control bank
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

`define SCR_ADDR_WDOG 5'h00
`define SCR_ADDR_STEP 5'h01
`define SCR_ADDR_DIR 5'h02
`define SCR_ADDR_MOT 5'h03
`define SCR_NUM_REGS 5'h04

`define SCR_IDX_WDOG 2'h0
`define SCR_IDX_STEP 2'h1
`define SCR_IDX_DIR 2'h2
`define SCR_IDX_MOT 2'h3

`define SCR_RESET_VAL 8'h00
`define SCR_READ_ZERO 8'h00
`define SCR_MASK_WDOG 8'hf8
`define SCR_MASK_STEP 8'hff
`define SCR_MASK_DIR 8'hcf
`define SCR_MASK_MOT 8'hf0

`define SCR_BIT_WD_EN 7
`define SCR_WDT_HI 6
`define SCR_WDT_LO 3
`define SCR_SM_HI 7
`define SCR_SM_LO 5
`define SCR_CUR_HI 4
`define SCR_CUR_LO 0
`define SCR_BIT_DIR_INV 7
`define SCR_BIT_STEP_POL 6
`define SCR_BIT_PWM_DBL 3
`define SCR_BIT_PWM_JIT 2
`define SCR_SLOPE_HI 1
`define SCR_SLOPE_LO 0
`define SCR_BIT_MOT_EN 7
`define SCR_BIT_SLEEP 6
`define SCR_BIT_SLA_GAIN 5
`define SCR_BIT_SLA_TRANSP 4

`define SCR_SM_NOT_AVAIL 3'h7

`define SCR_CMD_READ 3'h0
`define SCR_CMD_WRITE 3'h4
`define SCR_CMD_LEN_LAST 5'h07
`define SCR_WRITE_LEN 5'h10
`define SCR_LEN_SAT 5'h11
`define SCR_BYTE_LAST 3'h7
`define SCR_BYTE_WRAP 3'h0

`define SCR_CORE_CLK_KHZ 20000
`define SCR_WDOG_UNIT_MS 32
`define SCR_WDOG_UNIT_CYCLES (`SCR_WDOG_UNIT_MS * `SCR_CORE_CLK_KHZ)

`endif

//--- src/scr_spi_port.sv
// spi mode-0 slave, sampled in the core clock domain
`timescale 1ns/1ps
`include "scr_regs.svh"
module scr_spi_port
  import scr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_stb,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data
);

  scr_spi_s q, d;
  logic rise, fall, cs_rise;
  logic [7:0] byte_in;

  always_comb begin
    d = q;
    d.sclk_q = spi_sclk;
    d.csn_q = spi_cs_n;
    d.wr_stb = 1'b0;
    // sclk must be slower than half the core clock for these edges
    rise = ~spi_cs_n & scr_edge(spi_sclk, q.sclk_q, 1'b0);
    fall = ~spi_cs_n & scr_edge(spi_sclk, q.sclk_q, 1'b1);
    cs_rise = scr_edge(spi_cs_n, q.csn_q, 1'b0);
    byte_in = {q.shin[6:0], spi_mosi};
    if (spi_cs_n) begin
      d.phase = SCR_PH_IDLE;
      d.bitpos = '0;
      d.len = '0;
      // only an exact 16-bit write frame commits
      if (cs_rise && q.wr_cmd && q.len == `SCR_WRITE_LEN) begin
        d.wr_stb = 1'b1;
      end
      d.wr_cmd = 1'b0;
    end else begin
      if (q.phase == SCR_PH_IDLE) begin
        d.phase = SCR_PH_CMD;
      end
      if (rise) begin
        d.shin = byte_in;
        d.bitpos = q.bitpos + 3'h1;
        if (q.len != `SCR_LEN_SAT) begin
          d.len = q.len + 5'h01;
        end
        if (q.bitpos == `SCR_BYTE_LAST) begin
          unique case (q.phase)
            SCR_PH_DATA: begin
              d.wdata = byte_in;
              d.phase = SCR_PH_CMD;
            end
            default: begin
              d.addr = byte_in[4:0];
              if (byte_in[7:5] == `SCR_CMD_WRITE &&
                  q.len == `SCR_CMD_LEN_LAST) begin
                d.wr_cmd = 1'b1;
                d.phase = SCR_PH_DATA;
              end else begin
                d.phase = SCR_PH_CMD;
              end
            end
          endcase
        end
      end
      if (fall) begin
        // reload with the addressed register on each eighth falling edge
        if (q.bitpos == `SCR_BYTE_WRAP && q.len != 5'h00) begin
          d.shout = rd_data;
        end else begin
          d.shout = {q.shout[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      // select idles high, so release shows no false frame end
      q.csn_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign spi_miso = q.shout[7];
  assign spi_miso_oe = ~spi_cs_n;
  assign rd_addr = q.addr;
  assign wr_stb = q.wr_stb;
  assign wr_addr = q.addr;
  assign wr_data = q.wdata;

endmodule

//--- src/scr_watchdog.sv
// watchdog timer with (select+1) x unit timeout and sticky event flag
`timescale 1ns/1ps
`include "scr_regs.svh"
module scr_watchdog
  import scr_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `SCR_WDOG_UNIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic kick,
  input wire logic clear_flag,
  input wire logic [3:0] timeout_sel,
  output logic event_flag,
  output logic timeout
);

  scr_wdog_s q, d;
  logic tick, fire;

  always_comb begin
    d = q;
    tick = q.div == 20'(UNIT_CYCLES - 1);
    fire = enable & ~kick & tick & (q.units == timeout_sel);
    d.timeout = fire;
    // disabled or freshly written: count restarts from zero
    if (kick || !enable) begin
      d.div = '0;
      d.units = '0;
    end else if (tick) begin
      d.div = '0;
      d.units = fire ? 4'h0 : q.units + 4'h1;
    end else begin
      d.div = q.div + 20'h00001;
    end
    // a timeout in the clearing cycle keeps the flag set
    if (fire) begin
      d.flag = 1'b1;
    end else if (clear_flag) begin
      d.flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign event_flag = q.flag;
  assign timeout = q.timeout;

endmodule

//--- test/scr_asserts.sv
// port-level property checks for the control bank
`timescale 1ns/1ps
module scr_asserts (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic step_input,
  input wire logic step_advance,
  input wire logic dir_ccw,
  input wire logic [2:0] step_mode_select,
  input wire logic step_mode_valid,
  input wire logic [4:0] current_amplitude_select,
  input wire logic motor_enable,
  input wire logic sleep_mode,
  input wire logic watchdog_enable,
  input wire logic watchdog_event_flag,
  input wire logic watchdog_timeout
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_reset_clear: assert property (disable iff (1'b0) srst |=>
    !motor_enable && !watchdog_enable && current_amplitude_select == 5'h0)
    else $error("field not clear after reset");
  chk_mode_valid: assert property (
    step_mode_valid == (step_mode_select != 3'h7))
    else $error("step mode valid flag wrong");
  chk_sleep_step: assert property (
    sleep_mode && $past(sleep_mode) |-> !step_advance)
    else $error("step pulse while asleep");
  chk_sleep_dir: assert property (
    sleep_mode && $past(sleep_mode) |-> $stable(dir_ccw))
    else $error("direction moved while asleep");
  chk_step_edge: assert property (
    step_advance |-> $past(step_input) != $past(step_input, 2))
    else $error("step pulse without input edge");
  chk_wd_flag_set: assert property (
    watchdog_timeout |=> watchdog_event_flag || !watchdog_enable)
    else $error("timeout did not set event flag");
  chk_wd_stopped: assert property (
    !watchdog_enable [*3] |-> !watchdog_timeout)
    else $error("timeout while watchdog off");
  chk_wd_spacing: assert property (
    watchdog_timeout |=> !watchdog_timeout [*6])
    else $error("timeouts too close together");
  chk_wd_clear: assert property (
    $fell(watchdog_enable) && !watchdog_timeout |-> ##[0:2]
      !watchdog_event_flag)
    else $error("event flag not cleared on disable");
endmodule

bind scr_control_bank scr_asserts scr_asserts_inst (.core_clk, .srst,
  .step_input, .step_advance, .dir_ccw, .step_mode_select,
  .step_mode_valid, .current_amplitude_select, .motor_enable, .sleep_mode,
  .watchdog_enable, .watchdog_event_flag, .watchdog_timeout);

//--- test/scr_spi_master.sv
// spi mode-0 host model driving the control bank
`timescale 1ns/1ps
module scr_spi_master (
  input wire logic core_clk,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b1;
  end
  // three core cycles per phase, above the two the sampler needs
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0;
    @(negedge core_clk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = tx[15-i];
      repeat (3) @(negedge core_clk);
      rx = {rx[14:0], miso};
      sclk = 1'b1;
      repeat (3) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge core_clk);
    cs_n = 1'b1;
    // released data line must not look valid
    mosi = ~mosi;
    repeat (4) @(negedge core_clk);
  endtask
endmodule

//--- test/stepper_control_register_bank_tb_top.sv
// self-checking bench for the stepper control bank
`timescale 1ns/1ps
`include "scr_regs.svh"
module stepper_control_register_bank_tb_top;
  logic core_clk = 0, srst = 1, step_input = 0, dir_input = 0;
  logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, step_advance;
  logic dir_ccw, step_mode_valid, pwm_double_freq, pwm_jitter_en;
  logic motor_enable, sleep_mode, sla_gain_quarter, sla_transparent;
  logic watchdog_enable, watchdog_event_flag, watchdog_timeout;
  logic [2:0] step_mode_select;
  logic [4:0] current_amplitude_select;
  logic [1:0] slope_select;
  logic [7:0] exp_q[$];
  logic [7:0] rd_val;
  logic [7:0] fo [4];
  logic [7:0] out_mask [4] = '{8'h80, 8'hff, 8'h0f, 8'hf0};
  logic [7:0] reg_mask [4] = '{`SCR_MASK_WDOG, `SCR_MASK_STEP,
                               `SCR_MASK_DIR, `SCR_MASK_MOT};
  int err_count = 0, checked = 0, pulses = 0, wd_hits = 0;
  event rd_ev;
  // pull-up on the data-out line when deselected
  wire miso_w = spi_miso_oe ? spi_miso : 1'b1;
  assign fo[0] = {watchdog_enable, 7'h0};
  assign fo[1] = {step_mode_select, current_amplitude_select};
  assign fo[2] = {4'h0, pwm_double_freq, pwm_jitter_en, slope_select};
  assign fo[3] = {motor_enable, sleep_mode, sla_gain_quarter,
                  sla_transparent, 4'h0};
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (step_advance === 1'b1) pulses++;
  always @(posedge core_clk) if (watchdog_timeout === 1'b1) wd_hits++;
  scr_control_bank #(.WDOG_UNIT_CYCLES(8)) scr_control_bank_inst (
    .core_clk(core_clk), .srst(srst), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .step_input(step_input),
    .dir_input(dir_input), .step_advance(step_advance),
    .dir_ccw(dir_ccw), .step_mode_select(step_mode_select),
    .step_mode_valid(step_mode_valid),
    .current_amplitude_select(current_amplitude_select),
    .slope_select(slope_select), .pwm_double_freq(pwm_double_freq),
    .pwm_jitter_en(pwm_jitter_en), .motor_enable(motor_enable),
    .sleep_mode(sleep_mode), .sla_gain_quarter(sla_gain_quarter),
    .sla_transparent(sla_transparent),
    .watchdog_enable(watchdog_enable),
    .watchdog_event_flag(watchdog_event_flag),
    .watchdog_timeout(watchdog_timeout));
  scr_spi_master scr_spi_master_inst (.core_clk, .cs_n(spi_cs_n),
    .sclk(spi_sclk), .mosi(spi_mosi), .miso(miso_w));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [15:0] rx;
    scr_spi_master_inst.frame({`SCR_CMD_WRITE, a, d}, 16, rx);
    repeat (2) @(negedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [15:0] rx;
    exp_q.push_back(e);
    scr_spi_master_inst.frame({`SCR_CMD_READ, a, 8'h0}, 16, rx);
    rd_val = rx[7:0];
    ->rd_ev;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  always @(rd_ev) check(rd_val, exp_q.pop_front());
  initial begin
    tick(40000);
    err_count++;
    stop_test();
  end
  initial begin
    logic [7:0] d;
    logic [15:0] rx;
    d = $urandom(32'he6c2);
    tick(4);
    srst = 0;
    for (int a = 0; a < 4; a++) rd(a[4:0], `SCR_RESET_VAL);
    for (int a = 0; a < 4; a++) begin
      d = $urandom;
      wr(a[4:0], d);
      check(fo[a], d & out_mask[a]);
      rd(a[4:0], d & reg_mask[a]);
    end
    wr(5'h04, 8'hff);
    rd(5'h04, `SCR_READ_ZERO);
    wr(`SCR_ADDR_MOT, 8'h80);
    scr_spi_master_inst.frame({`SCR_CMD_WRITE, 5'h03, 8'hff}, 15, rx);
    rd(`SCR_ADDR_MOT, 8'h80);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      wr(`SCR_ADDR_STEP, {i[2:0], 5'h0});
      check({7'h0, step_mode_valid}, {7'h0, i != 7});
      wr(`SCR_ADDR_DIR, {6'h0, i[1:0]});
      check({6'h0, slope_select}, {6'h0, i[1:0]});
    end
    $display("code test done");
    for (int i = 0; i < 5; i++) begin
      if (i < 4) wr(`SCR_ADDR_DIR, {i[1], i[0], 6'h0});
      else wr(`SCR_ADDR_MOT, 8'hc0);
      dir_input = i[0];
      pulses = 0;
      tick(4);
      step_input = 1;
      tick(4);
      if (i < 4) check(pulses[7:0], {7'h0, ~i[0]});
      step_input = 0;
      tick(4);
      check(pulses[7:0], {7'h0, i < 4});
      check({7'h0, dir_ccw}, {7'h0, i == 1 || i == 2});
    end
    rd(`SCR_ADDR_MOT, 8'hc0);
    $display("step test done");
    wr(`SCR_ADDR_WDOG, 8'h00);
    // second clear: a timeout may meet the first one and win
    wr(`SCR_ADDR_WDOG, 8'h00);
    wr(`SCR_ADDR_WDOG, 8'h88);
    wd_hits = 0;
    tick(8);
    check({7'h0, watchdog_event_flag}, 8'h0);
    tick(12);
    check({7'h0, watchdog_event_flag}, 8'h1);
    check(wd_hits[7:0], 8'h01);
    wr(`SCR_ADDR_WDOG, 8'h08);
    check({7'h0, watchdog_event_flag}, 8'h0);
    wd_hits = 0;
    tick(40);
    check({7'h0, watchdog_event_flag}, 8'h0);
    check(wd_hits[7:0], 8'h00);
    $display("watchdog test done");
    srst = 1;
    tick(4);
    srst = 0;
    rd(`SCR_ADDR_MOT, `SCR_RESET_VAL);
    $display("reset test done");
    tick(2);
    stop_test();
  end
endmodule
